// ### verilog/lpts_sequencer.sv
// Drive-to-mains transfer sequencer with APB registers
//
// Overview of operation
// - Mode register picks off or one of three triggers; frozen while running.
// - When enabled, trip, frequency or input moves motor to mains.
// - Output frequency reaching switching frequency starts the transfer.
// - Transfer input forces speed ramp to switching frequency, then transfer.
// - Input release starts drive hold timer; expiry returns motor to drive.
// - Drive output applied only after its own hold time.
// - Mains applied only after the pre-apply hold time, except when input returns during the drive hold.
// - Mains held applied for the apply hold time, except when input returns during the drive hold.
// - Two contactor outputs reroute motor between drive and mains.
// - Switching frequency resets to 60.00 Hz.
`timescale 1ns/1ns
`default_nettype none
module lpts_sequencer
  import lpts_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic driveRunning,
  input wire logic driveTrip,
  input wire logic [15:0] outputFreq,
  input wire logic transferInput,
  output logic forceSwitchFreq,
  output logic contactor_output_one,
  output logic contactor_output_two
);
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [1:0] modeQ_q, modeQ_d;
  logic [15:0] freq_q, freq_d;
  logic [15:0] holdDrv_q, holdDrv_d;
  logic [15:0] holdPre_q, holdPre_d;
  logic [15:0] holdApp_q, holdApp_d;
  logic [31:0] prdata_d;
  logic wrEn, rdEn, mapped;
  lpts_state_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic tick;

  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr == REG_MODE) || (paddr == REG_FREQ) ||
    (paddr == REG_HOLD_DRV) || (paddr == REG_HOLD_PRE) ||
    (paddr == REG_HOLD_APPLY) || (paddr == REG_STATUS);
  assign pslverr = psel && penable && !mapped;

  always_comb begin
    modeQ_d = modeQ_q;
    freq_d = freq_q;
    holdDrv_d = holdDrv_q;
    holdPre_d = holdPre_q;
    holdApp_d = holdApp_q;
    if (wrEn) begin
      unique case (paddr)
        // Changing the mode under a running motor is ignored
        REG_MODE: if (!driveRunning) modeQ_d = pwdata[1:0];
        REG_FREQ: freq_d = pwdata[15:0];
        REG_HOLD_DRV: holdDrv_d = pwdata[15:0];
        REG_HOLD_PRE: holdPre_d = pwdata[15:0];
        REG_HOLD_APPLY: holdApp_d = pwdata[15:0];
        default: ;
      endcase
    end
    prdata_d = prdata;
    if (rdEn) begin
      unique case (paddr)
        REG_MODE: prdata_d = {30'h0, modeQ_q};
        REG_FREQ: prdata_d = {16'h0, freq_q};
        REG_HOLD_DRV: prdata_d = {16'h0, holdDrv_q};
        REG_HOLD_PRE: prdata_d = {16'h0, holdPre_q};
        REG_HOLD_APPLY: prdata_d = {16'h0, holdApp_q};
        REG_STATUS: prdata_d = {26'h0, forceSwitchFreq,
          contactor_output_two, contactor_output_one, 3'(state_q)};
        default: prdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      modeQ_q <= MODE_RESET;
      freq_q <= SWITCH_FREQ_RESET;
      holdDrv_q <= HOLD_RESET;
      holdPre_q <= HOLD_RESET;
      holdApp_q <= HOLD_RESET;
      prdata <= 32'h0;
    end else begin
      modeQ_q <= modeQ_d;
      freq_q <= freq_d;
      holdDrv_q <= holdDrv_d;
      holdPre_q <= holdPre_d;
      holdApp_q <= holdApp_d;
      prdata <= prdata_d;
    end
  end

  // ----------------------------------------
  // Hold timer base
  // ----------------------------------------
  lpts_tick_div #(.DIV(TICK_DIV)) uDiv (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic tripEn, freqEn, atFreq, expired;
  assign tripEn = (modeQ_q == MODE_SIG_TRIP) ||
    (modeQ_q == MODE_SIG_TRIP_FREQ);
  assign freqEn = (modeQ_q == MODE_SIG_FREQ) ||
    (modeQ_q == MODE_SIG_TRIP_FREQ);
  assign atFreq = outputFreq >= freq_q;
  assign expired = (cnt_q == 16'h0);

  always_comb begin
    state_d = state_q;
    cnt_d = (tick && !expired) ? cnt_q - 16'h1 : cnt_q;
    unique case (state_q)
      ST_DRIVE: begin
        if (modeQ_q != MODE_OFF) begin
          if ((tripEn && driveTrip) || (freqEn && atFreq)) begin
            state_d = ST_PRE;
            cnt_d = holdPre_q;
          end else if (transferInput) begin
            state_d = ST_RAMP;
          end
        end
      end
      ST_RAMP: begin
        if (atFreq || (tripEn && driveTrip)) begin
          state_d = ST_PRE;
          cnt_d = holdPre_q;
        end else if (!transferInput) begin
          state_d = ST_DRIVE;
        end
      end
      ST_PRE: begin
        // Both contactors open while the pre-apply hold runs; leaving
        // only on a tick after zero keeps each hold at least as set, except mains re-entry from ST_BACK_WAIT, which loads zero
        if (expired && tick) begin
          state_d = ST_MAINS;
          cnt_d = holdApp_q;
        end
      end
      ST_MAINS: begin
        // Mains stays for the apply hold, none after a return from the drive hold; return only on input release
        if (expired && tick && !transferInput && !driveTrip) begin
          state_d = ST_BACK_WAIT;
          cnt_d = holdDrv_q;
        end
      end
      ST_BACK_WAIT: begin
        if (transferInput) begin
          state_d = ST_MAINS;
          cnt_d = 16'h0;
        end else if (expired && tick) begin
          state_d = ST_DRIVE;
        end
      end
      default: state_d = ST_DRIVE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_DRIVE;
      cnt_q <= 16'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // Outputs decoded from state only, so they can never overlap
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      contactor_output_one <= 1'b1;
      contactor_output_two <= 1'b0;
      forceSwitchFreq <= 1'b0;
    end else begin
      contactor_output_one <= (state_d == ST_DRIVE) ||
        (state_d == ST_RAMP);
      contactor_output_two <= (state_d == ST_MAINS);
      forceSwitchFreq <= (state_d == ST_RAMP);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_excl;
    @(posedge sys_clk) disable iff (rst)
      !(contactor_output_one && contactor_output_two);
  endproperty
  a_excl: assert property (p_excl)
    else $error("both contactors on");
  property p_freq_reset;
    @(posedge sys_clk) $fell(rst) |-> freq_q == SWITCH_FREQ_RESET;
  endproperty
  a_freq_reset: assert property (p_freq_reset)
    else $error("bad freq");
  property p_mode_frozen;
    @(posedge sys_clk) disable iff (rst)
      driveRunning |=> $stable(modeQ_q);
  endproperty
  a_mode_frozen: assert property (p_mode_frozen)
    else $error("mode moved");
  property p_trigger;
    @(posedge sys_clk) disable iff (rst)
      (state_q == ST_DRIVE && freqEn && atFreq) |=> state_q == ST_PRE;
  endproperty
  a_trigger: assert property (p_trigger) else $error("no transfer");
  property p_trip;
    @(posedge sys_clk) disable iff (rst)
      (state_q == ST_DRIVE && tripEn && driveTrip) |=> state_q == ST_PRE;
  endproperty
  a_trip: assert property (p_trip) else $error("trip ignored");
  property p_ramp;
    @(posedge sys_clk) disable iff (rst)
      (state_q == ST_DRIVE && modeQ_q != MODE_OFF && transferInput &&
        !driveTrip && !atFreq) |=> forceSwitchFreq;
  endproperty
  a_ramp: assert property (p_ramp) else $error("no ramp force");
  property p_pre_open;
    @(posedge sys_clk) disable iff (rst)
      (state_q == ST_PRE && !expired) |=> !contactor_output_two;
  endproperty
  a_pre_open: assert property (p_pre_open)
    else $error("mains early");
  property p_back;
    @(posedge sys_clk) disable iff (rst)
      (state_q == ST_BACK_WAIT && !expired) |=> !contactor_output_one;
  endproperty
  a_back: assert property (p_back) else $error("drive early");
  property p_hold_mains;
    @(posedge sys_clk) disable iff (rst)
      (state_q == ST_MAINS && !expired) |=> state_q == ST_MAINS;
  endproperty
  a_hold_mains: assert property (p_hold_mains)
    else $error("mains left");
  c_pre: cover property (@(posedge sys_clk) state_q == ST_PRE);
  c_mains: cover property (@(posedge sys_clk) state_q == ST_MAINS);
  c_back: cover property (@(posedge sys_clk) state_q == ST_BACK_WAIT);
endmodule
`default_nettype wire

// ### verilog/lpts_pkg.sv
// Package of constants and types for the line power transfer sequencer
package lpts_pkg;
  // Transfer mode encodings
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SIG_TRIP = 2'h1;
  localparam logic [1:0] MODE_SIG_FREQ = 2'h2;
  localparam logic [1:0] MODE_SIG_TRIP_FREQ = 2'h3;
  localparam logic [1:0] MODE_RESET = MODE_OFF;
  // Frequency in units of 0.01 Hz
  localparam int FREQ_W = 16;
  localparam logic [15:0] SWITCH_FREQ_RESET = 16'h1770;
  // Hold times in units of 0.1 s
  localparam int HOLD_W = 16;
  localparam logic [15:0] HOLD_RESET = 16'h0000;
  localparam int CLK_HZ = 25000000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // APB register byte offsets
  localparam logic [7:0] REG_MODE = 8'h00;
  localparam logic [7:0] REG_FREQ = 8'h04;
  localparam logic [7:0] REG_HOLD_DRV = 8'h08;
  localparam logic [7:0] REG_HOLD_PRE = 8'h0C;
  localparam logic [7:0] REG_HOLD_APPLY = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  typedef enum logic [2:0] {
    ST_DRIVE, ST_RAMP, ST_PRE, ST_MAINS, ST_BACK_WAIT
  } lpts_state_t;
endpackage

// ### verilog/lpts_tick_div.sv
// Divider giving a one-cycle tick every tick period
`timescale 1ns/1ns
`default_nettype none
module lpts_tick_div
  import lpts_pkg::*;
#(
  parameter int DIV = TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  output logic tick
);
  // ----------------------------------------
  // Counter
  // ----------------------------------------
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  // A divide below one has no tick to give, so refuse it at elaboration
  if (DIV < 1) begin : gDivCheck
    $error("lpts_tick_div: DIV must be positive");
  end
  always_comb begin
    if (cnt_q >= 32'(DIV - 1)) begin
      cnt_d = 32'h0;
    end else begin
      cnt_d = cnt_q + 32'h1;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign tick = (cnt_q >= 32'(DIV - 1));
endmodule
`default_nettype wire

// ### verif/lpts_motor_model.sv
// Behavioural motor, terminal and contactor side for the sequencer bench
`timescale 1ns/1ns
`default_nettype none
module lpts_motor_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic termCmd,
  input wire logic [15:0] freqSet,
  input wire logic forceSwitchFreq,
  input wire logic contactor_output_one,
  input wire logic contactor_output_two,
  output logic transferInput,
  output logic [15:0] outputFreq
);
  // Same rotation on both paths, all directions permitted
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      transferInput <= 1'b0;
      outputFreq <= 16'h0000;
    end else begin
      transferInput <= termCmd;
      // Coarse ramp so the bench never waits long for the target
      // Drive can only push the motor up while its own contactor is closed
      outputFreq <= (forceSwitchFreq && contactor_output_one) ?
        outputFreq + 16'h0200 : freqSet;
    end
  end
endmodule
`default_nettype wire

// ### verif/lpts_sequencer_tb_top.sv
// Self-checking bench for the line power transfer sequencer
`timescale 1ns/1ns
`default_nettype none
module lpts_sequencer_tb_top;
  import lpts_pkg::*;
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic driveRunning, driveTrip, transferInput, forceSwitchFreq;
  logic one, two, termCmd;
  logic [15:0] outputFreq, freqSet, rnd, sw;
  logic [31:0] expQ[$];
  int errCount, samplesChecked, n;
  lpts_sequencer #(.TICK_DIV(4)) dut(.sys_clk(sys_clk), .rst(rst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .driveRunning(driveRunning), .driveTrip(driveTrip),
    .outputFreq(outputFreq), .transferInput(transferInput),
    .forceSwitchFreq(forceSwitchFreq), .contactor_output_one(one),
    .contactor_output_two(two));
  lpts_motor_model model(.sys_clk(sys_clk), .rst(rst), .termCmd(termCmd),
    .freqSet(freqSet), .forceSwitchFreq(forceSwitchFreq),
    .contactor_output_one(one), .contactor_output_two(two),
    .transferInput(transferInput), .outputFreq(outputFreq));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errCount++;
      $display("CHECK FAILED t=%0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task testDone;
    $display("checks %0d mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task endTest(input string s);
    $display("test %s done", s);
  endtask
  function logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Reads queue the expected word; the monitor below compares it
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) expQ.push_back(d);
    @(posedge sys_clk);
    penable <= 1'b1;
    // Wait states are the slave's call; only the watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function logic sig(input int i);
    sig = i == 0 ? one : (i == 1 ? two : forceSwitchFreq);
  endfunction
  task waitSig(input int i, input logic v);
    n = 0;
    while (sig(i) !== v && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000) chk(32'h0, 32'h1);
  endtask
  always @(posedge sys_clk) begin
    if (psel && penable) chk({31'h0, pready}, 32'h1);
    if (psel && penable && pready === 1'b1) begin
      chk({31'h0, pslverr}, {31'h0, paddr > 8'h14});
      if (!pwrite) chk(prdata, expQ.pop_front());
    end
    if (!rst) chk({31'h0, one & two}, 32'h0);
  end
  initial begin
    #800000;
    errCount++;
    testDone;
  end
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {driveRunning, driveTrip, termCmd, freqSet} = '0;
    rnd = 16'h6EE1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    chk({31'h0, one}, 32'h1);
    apb(1'b0, REG_FREQ, 32'h1770);
    apb(1'b0, REG_MODE, 32'h0);
    apb(1'b1, REG_STATUS, 32'hFF);
    apb(1'b0, REG_STATUS, 32'h8);
    apb(1'b0, 8'h18, 32'h0);
    apb(1'b1, REG_HOLD_PRE, 32'h2);
    apb(1'b1, REG_HOLD_APPLY, 32'h3);
    apb(1'b1, REG_HOLD_DRV, 32'h2);
    apb(1'b0, REG_HOLD_APPLY, 32'h3);
    driveRunning <= 1'b1;
    apb(1'b1, REG_MODE, 32'h3);
    apb(1'b0, REG_MODE, 32'h0);
    driveRunning <= 1'b0;
    termCmd <= 1'b1;
    driveTrip <= 1'b1;
    repeat (30) @(posedge sys_clk);
    chk({30'h0, one, forceSwitchFreq}, 32'h2);
    termCmd <= 1'b0;
    driveTrip <= 1'b0;
    endTest("reset_and_off");
    apb(1'b1, REG_MODE, 32'h1);
    driveTrip <= 1'b1;
    waitSig(0, 1'b0);
    chk({31'h0, two}, 32'h0);
    waitSig(1, 1'b1);
    chk({31'h0, (n >= 7 && n <= 14)}, 32'h1);
    repeat (40) @(posedge sys_clk);
    chk({31'h0, two}, 32'h1);
    driveTrip <= 1'b0;
    waitSig(1, 1'b0);
    waitSig(0, 1'b1);
    chk({31'h0, (n >= 7 && n <= 14)}, 32'h1);
    endTest("trip");
    rnd = lfsr(rnd);
    sw = {4'h0, rnd[11:0]} + 16'h0400;
    apb(1'b1, REG_MODE, 32'h2);
    apb(1'b1, REG_FREQ, {16'h0, sw});
    freqSet <= sw - 16'h0001;
    driveTrip <= 1'b1;
    repeat (30) @(posedge sys_clk);
    chk({31'h0, one}, 32'h1);
    driveTrip <= 1'b0;
    freqSet <= sw;
    waitSig(1, 1'b1);
    chk({31'h0, forceSwitchFreq}, 32'h0);
    freqSet <= 16'h0000;
    waitSig(0, 1'b1);
    endTest("frequency");
    apb(1'b1, REG_MODE, 32'h3);
    termCmd <= 1'b1;
    waitSig(2, 1'b1);
    chk({31'h0, one}, 32'h1);
    waitSig(1, 1'b1);
    termCmd <= 1'b0;
    waitSig(1, 1'b0);
    chk({31'h0, (n >= 10 && n <= 18)}, 32'h1);
    waitSig(0, 1'b1);
    chk({31'h0, (n >= 7 && n <= 14)}, 32'h1);
    endTest("input");
    testDone;
  end
endmodule
`default_nettype wire
